// ---- health_defs.svh ----
// Constants for the health status aggregator: field ids, bit positions, resets
`ifndef HEALTH_DEFS_SVH
`define HEALTH_DEFS_SVH

// Health word bit positions
`define HW_FATAL_BIT      0
`define HW_HWERR_BIT      1
`define HW_LINKERR_BIT    2
`define HW_SWERR_BIT      3
`define HW_ALERT_BIT      8
`define HW_HWALERT_BIT    9
`define HW_LINKALERT_BIT  10
`define HW_SWALERT_BIT    11
`define HW_SENSALERT_BIT  12

// Field identifiers for read and write field commands
`define FID_HW_ALERT_EN   16'h0010
`define FID_LINK_ALERT_EN 16'h0011
`define FID_SW_ALERT_EN   16'h0012
`define FID_SENS_ALERT_EN 16'h0013
`define FID_HEALTH        16'h0100
`define FID_HW_ERR        16'h0101
`define FID_POWER         16'h0102
`define FID_ENV           16'h0103
`define FID_LINK_ERR      16'h0104
`define FID_PORT_A        16'h0105
`define FID_PORT_B        16'h0106
`define FID_SW_ERR        16'h0107

// Reset values
`define WORD_RST          16'h0000
`define HW_ALERT_EN_RST   16'h0000
`define LINK_ALERT_EN_RST 16'h0001
`define SW_ALERT_EN_RST   16'h0003
`define SENS_ALERT_EN_RST 16'h0001

// Persistence counter defaults
`define PERSIST_CNT_W     8
`define PERSIST_INC       8'h04
`define PERSIST_DECAY     8'h01
`define PERSIST_THRESH    8'h10

`endif

// ---- health_pkg.sv ----
// Types shared by the health status aggregator files
package health_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  persist_cnt_t;
endpackage

// ---- persist_filter.sv ----
// Low-pass persistence counter between soft failures and the fatal flag
`timescale 1ns/1ns
`include "health_defs.svh"

module persist_filter #(
  parameter health_pkg::persist_cnt_t INC    = `PERSIST_INC,
  parameter health_pkg::persist_cnt_t DECAY  = `PERSIST_DECAY,
  parameter health_pkg::persist_cnt_t THRESH = `PERSIST_THRESH
) (
  input  wire logic sys_clk,  // System clock
  input  wire logic rst_n,    // Async reset
  input  wire logic softErr,  // Any soft failure this cycle
  output logic      trip      // Persistence met
);
  health_pkg::persist_cnt_t cntReg;
  health_pkg::persist_cnt_t cntNext;
  logic [8:0] sum;

  // Saturating up on error, decaying toward zero otherwise
  always_comb begin
    sum = {1'b0, cntReg} + {1'b0, INC};
    if (softErr) begin
      cntNext = sum[8] ? 8'hff : sum[7:0];
    end else if (cntReg > DECAY) begin
      cntNext = cntReg - DECAY;
    end else begin
      cntNext = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 8'h00;
    end else begin
      cntReg <= cntNext;
    end
  end

  assign trip = (cntReg >= THRESH);

  // Trip may only rise right after a soft error pushed the count up
  a_trip_threshold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(trip) |-> $past(softErr)
    ) else $error("trip rose without a soft error");

  a_decay_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!softErr && cntReg > DECAY) |=> cntReg == $past(cntReg) - DECAY
    ) else $error("counter failed to decay");

  a_count_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_n && softErr && cntReg <= 8'hff - INC) |=> cntReg == $past(cntReg) + INC
    ) else $error("counter failed to step up");
endmodule

// ---- health_status_aggregator.sv ----
// Built-in-test and alert status roll-up tree with field read and write port
`timescale 1ns/1ns
`include "health_defs.svh"

module health_status_aggregator #(
  parameter health_pkg::persist_cnt_t PERSIST_INC    = `PERSIST_INC,
  parameter health_pkg::persist_cnt_t PERSIST_DECAY  = `PERSIST_DECAY,
  parameter health_pkg::persist_cnt_t PERSIST_THRESH = `PERSIST_THRESH
) (
  input  wire logic                sys_clk,          // System clock
  input  wire logic                rst_n,            // Async reset, low
  input  wire logic                inputPowerOob,    // Input power out of bounds
  input  wire logic                inputCurrentOob,  // Input current out of bounds
  input  wire logic                inputVoltageOob,  // Input voltage out of bounds
  input  wire logic                rail5vOob,        // 5 V rail out of bounds
  input  wire logic                rail3vOob,        // 3 V rail out of bounds
  input  wire logic                rail2vOob,        // 2 V rail out of bounds
  input  wire logic                ref2v5Oob,        // 2.5 V reference out of bounds
  input  wire logic                rail6vOob,        // 6 V rail out of bounds
  input  wire logic                groundRefOob,     // Ground reference out of bounds
  input  wire logic                boardTempOob,     // Board temperature out of bounds
  input  wire logic                portATxOverflow,  // Port A transmit overflow
  input  wire logic                portARxOverflow,  // Port A receive overflow
  input  wire logic                portAFrameFault,  // Port A framing error
  input  wire logic                portALineBreak,   // Port A break detected
  input  wire logic                portAParityFault, // Port A parity error
  input  wire logic                portBTxOverflow,  // Port B transmit overflow
  input  wire logic                portBRxOverflow,  // Port B receive overflow
  input  wire logic                portBFrameFault,  // Port B framing error
  input  wire logic                portBLineBreak,   // Port B break detected
  input  wire logic                portBParityFault, // Port B parity error
  input  wire logic                algoFault,        // Software algorithm fault
  input  wire logic                storedDataFault,  // Software data fault
  input  wire logic                hardFail,         // Any hard-category failure
  input  wire health_pkg::word_t   hwAlertStatus,    // Hardware alert indications
  input  wire health_pkg::word_t   linkAlertStatus,  // Link alert indications
  input  wire health_pkg::word_t   swAlertStatus,    // Software alert indications
  input  wire health_pkg::word_t   sensorAlertStatus,// Sensor alert indications
  input  wire logic                fieldRd,          // Read field strobe
  input  wire logic                fieldWr,          // Write field strobe
  input  wire health_pkg::word_t   fieldId,          // Field identifier
  input  wire health_pkg::word_t   fieldWrData,      // Write field data
  output health_pkg::word_t        fieldRdData,      // Read field data
  output logic                     fieldRdValid,     // Read answer pulse
  output logic                     fieldAccErr,      // Unknown field pulse
  output health_pkg::word_t        healthWord,       // Health word
  output logic                     fatalFailPin      // Fatal failure pin
);

  health_pkg::word_t powerNext;
  health_pkg::word_t envNext;
  health_pkg::word_t hwErrNext;
  health_pkg::word_t portANext;
  health_pkg::word_t portBNext;
  health_pkg::word_t linkErrNext;
  health_pkg::word_t swErrNext;
  health_pkg::word_t healthNext;

  health_pkg::word_t powerReg;
  health_pkg::word_t envReg;
  health_pkg::word_t hwErrReg;
  health_pkg::word_t portAReg;
  health_pkg::word_t portBReg;
  health_pkg::word_t linkErrReg;
  health_pkg::word_t swErrReg;
  health_pkg::word_t healthReg;

  health_pkg::word_t hwAlertEnReg;
  health_pkg::word_t linkAlertEnReg;
  health_pkg::word_t swAlertEnReg;
  health_pkg::word_t sensAlertEnReg;

  health_pkg::word_t fieldRdDataReg;
  health_pkg::word_t rdMux;
  logic              rdHit;
  logic              fieldRdValidReg;
  logic              fieldAccErrReg;
  logic              wrHit;

  logic [3:0]        alertRaw;
  health_pkg::word_t alertStat [4];
  health_pkg::word_t alertEn   [4];
  logic              softAny;
  logic              persistTrip;

  // Leaf words; reserved bits tied low so they read zero
  always_comb begin
    powerNext      = `WORD_RST;
    powerNext[0]   = inputPowerOob;
    powerNext[1]   = inputCurrentOob;
    powerNext[2]   = inputVoltageOob;
    powerNext[3]   = rail5vOob;
    powerNext[4]   = rail3vOob;
    powerNext[5]   = rail2vOob;
    powerNext[6]   = ref2v5Oob;
    powerNext[7]   = rail6vOob;
    powerNext[8]   = groundRefOob;
    envNext        = `WORD_RST;
    envNext[0]     = boardTempOob;
    portANext      = `WORD_RST;
    portANext[4:0] = {portAParityFault, portALineBreak, portAFrameFault,
                      portARxOverflow, portATxOverflow};
    portBNext      = `WORD_RST;
    portBNext[4:0] = {portBParityFault, portBLineBreak, portBFrameFault,
                      portBRxOverflow, portBTxOverflow};
  end

  // Intermediate words; hardware and link bits are the OR of the word below, software bits take the leaves directly
  always_comb begin
    hwErrNext      = `WORD_RST;
    hwErrNext[0]   = |powerNext;
    hwErrNext[1]   = |envNext;
    linkErrNext    = `WORD_RST;
    linkErrNext[0] = |portANext;
    linkErrNext[1] = |portBNext;
    swErrNext      = `WORD_RST;
    swErrNext[0]   = algoFault;
    swErrNext[1]   = storedDataFault;
  end

  // Each alert category gathers only its enabled indications
  assign alertStat[0] = hwAlertStatus;
  assign alertStat[1] = linkAlertStatus;
  assign alertStat[2] = swAlertStatus;
  assign alertStat[3] = sensorAlertStatus;
  assign alertEn[0]   = hwAlertEnReg;
  assign alertEn[1]   = linkAlertEnReg;
  assign alertEn[2]   = swAlertEnReg;
  assign alertEn[3]   = sensAlertEnReg;

  for (genvar g = 0; g < 4; g++) begin : gAlert
    assign alertRaw[g] = |(alertStat[g] & alertEn[g]);
  end

  // Every leaf is soft, so any set flag feeds the persistence filter
  assign softAny = |hwErrNext | (|linkErrNext) | (|swErrNext);

  persist_filter #(
    .INC    (PERSIST_INC),
    .DECAY  (PERSIST_DECAY),
    .THRESH (PERSIST_THRESH)
  ) uPersist (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .softErr (softAny),
    .trip    (persistTrip)
  );

  always_comb begin
    healthNext                    = `WORD_RST;
    healthNext[`HW_FATAL_BIT]     = hardFail | persistTrip;
    healthNext[`HW_HWERR_BIT]     = |hwErrNext;
    healthNext[`HW_LINKERR_BIT]   = |linkErrNext;
    healthNext[`HW_SWERR_BIT]     = |swErrNext;
    healthNext[`HW_HWALERT_BIT]   = alertRaw[0];
    healthNext[`HW_LINKALERT_BIT] = alertRaw[1];
    healthNext[`HW_SWALERT_BIT]   = alertRaw[2];
    healthNext[`HW_SENSALERT_BIT] = alertRaw[3];
    healthNext[`HW_ALERT_BIT]     = |alertRaw;
  end

  // All words load together so every level of the tree agrees each cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerReg   <= `WORD_RST;
      envReg     <= `WORD_RST;
      hwErrReg   <= `WORD_RST;
      portAReg   <= `WORD_RST;
      portBReg   <= `WORD_RST;
      linkErrReg <= `WORD_RST;
      swErrReg   <= `WORD_RST;
      healthReg  <= `WORD_RST;
    end else begin
      powerReg   <= powerNext;
      envReg     <= envNext;
      hwErrReg   <= hwErrNext;
      portAReg   <= portANext;
      portBReg   <= portBNext;
      linkErrReg <= linkErrNext;
      swErrReg   <= swErrNext;
      healthReg  <= healthNext;
    end
  end

  // Enable masks, written by the write field command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hwAlertEnReg   <= `HW_ALERT_EN_RST;
      linkAlertEnReg <= `LINK_ALERT_EN_RST;
      swAlertEnReg   <= `SW_ALERT_EN_RST;
      sensAlertEnReg <= `SENS_ALERT_EN_RST;
    end else if (fieldWr) begin
      case (fieldId)
        `FID_HW_ALERT_EN:   hwAlertEnReg   <= fieldWrData;
        `FID_LINK_ALERT_EN: linkAlertEnReg <= fieldWrData;
        `FID_SW_ALERT_EN:   swAlertEnReg   <= fieldWrData;
        `FID_SENS_ALERT_EN: sensAlertEnReg <= fieldWrData;
        default: ;
      endcase
    end
  end

  assign wrHit = (fieldId == `FID_HW_ALERT_EN) || (fieldId == `FID_LINK_ALERT_EN) ||
                 (fieldId == `FID_SW_ALERT_EN) || (fieldId == `FID_SENS_ALERT_EN);

  // Field read decode
  always_comb begin
    rdHit = 1'b1;
    case (fieldId)
      `FID_HEALTH:        rdMux = healthReg;
      `FID_HW_ERR:        rdMux = hwErrReg;
      `FID_POWER:         rdMux = powerReg;
      `FID_ENV:           rdMux = envReg;
      `FID_LINK_ERR:      rdMux = linkErrReg;
      `FID_PORT_A:        rdMux = portAReg;
      `FID_PORT_B:        rdMux = portBReg;
      `FID_SW_ERR:        rdMux = swErrReg;
      `FID_HW_ALERT_EN:   rdMux = hwAlertEnReg;
      `FID_LINK_ALERT_EN: rdMux = linkAlertEnReg;
      `FID_SW_ALERT_EN:   rdMux = swAlertEnReg;
      `FID_SENS_ALERT_EN: rdMux = sensAlertEnReg;
      default: begin
        rdMux = `WORD_RST;
        rdHit = 1'b0;
      end
    endcase
  end

  // When both strobes arrive together the read decides the error flag; the write still lands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fieldRdDataReg  <= `WORD_RST;
      fieldRdValidReg <= 1'b0;
      fieldAccErrReg  <= 1'b0;
    end else begin
      fieldRdValidReg <= fieldRd && rdHit;
      fieldAccErrReg  <= fieldRd ? !rdHit : (fieldWr && !wrHit);
      if (fieldRd) begin
        fieldRdDataReg <= rdMux;
      end
    end
  end

  assign fieldRdData  = fieldRdDataReg;
  assign fieldRdValid = fieldRdValidReg;
  assign fieldAccErr  = fieldAccErrReg;
  assign healthWord   = healthReg;
  assign fatalFailPin = healthReg[`HW_FATAL_BIT];

  a_hw_err_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    healthReg[1] == |hwErrReg
    ) else $error("hardware summary differs from word OR");

  a_power_fault_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hwErrReg[0] == |powerReg
    ) else $error("power fault differs from word OR");

  a_env_fault_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hwErrReg[1] == |envReg
    ) else $error("environmental fault differs from word");

  a_link_err_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    healthReg[2] == |linkErrReg
    ) else $error("link summary differs from word OR");

  a_port_a_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkErrReg[0] == |portAReg
    ) else $error("port A fault differs from word OR");

  a_port_b_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkErrReg[1] == |portBReg
    ) else $error("port B fault differs from word OR");

  a_sw_err_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    healthReg[3] == |swErrReg
    ) else $error("software summary differs from word OR");

  a_alert_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
    healthReg[8] == |healthReg[12:9]
    ) else $error("alert summary differs from alert OR");

  // Checked against the raw inputs so a swapped category shows; the edge after reset still holds zeros
  a_alert_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> healthReg[9] == |($past(hwAlertStatus) & $past(hwAlertEnReg))
      && healthReg[10] == |($past(linkAlertStatus) & $past(linkAlertEnReg))
      && healthReg[11] == |($past(swAlertStatus) & $past(swAlertEnReg))
      && healthReg[12] == |($past(sensorAlertStatus) & $past(sensAlertEnReg))
    ) else $error("alert intermediate ignores mask");

  a_hard_fatal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hardFail |=> healthReg[0] && fatalFailPin
    ) else $error("hard failure did not assert fatal");

  a_soft_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (algoFault && !hardFail && !persistTrip) |=> healthReg[3] && !healthReg[0]
    ) else $error("soft failure handling wrong");

  a_fatal_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fatalFailPin == healthWord[0]
    ) else $error("fatal pin does not mirror flag");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    healthReg[7:4] == 4'h0 && healthReg[15:13] == 3'h0 && powerReg[15:9] == 7'h00
    && portAReg[15:5] == 11'h000 && hwErrReg[15:2] == 14'h0000
    ) else $error("reserved bit set");

  a_fatal_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(hardFail || persistTrip) |=> !healthReg[0]
    ) else $error("fatal set without hard failure or persistence");

  a_power_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> powerReg[0] == $past(inputPowerOob) && powerReg[8] == $past(groundRefOob)
    ) else $error("power flag in wrong bit");

  a_port_a_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> portAReg[0] == $past(portATxOverflow) && portAReg[4] == $past(portAParityFault)
    ) else $error("port A flag in wrong bit");

  a_port_b_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> portBReg[2] == $past(portBFrameFault) && portBReg[3] == $past(portBLineBreak)
    ) else $error("port B flag in wrong bit");
endmodule

// ---- tb_health_status_aggregator.sv ----
// Self-checking testbench for the health status aggregator
`timescale 1ns/1ns

module tb_health_status_aggregator;
  typedef struct {
    logic [21:0]       leaf;
    health_pkg::word_t hwA, linkA, swA, senA, rid, rexp, hexp;
  } row_t;
  localparam health_pkg::persist_cnt_t INC = 8'h04;
  localparam health_pkg::persist_cnt_t DEC = 8'h01;
  // Short threshold keeps the fatal walk brief; expectations derive from it
  localparam health_pkg::persist_cnt_t THR = 8'h08;
  localparam int                       TIMEOUT = 2000;

  logic              sys_clk     = 1'b0;
  logic              rst_n       = 1'b0;
  logic [21:0]       leaf        = 22'h000000;
  logic              hard        = 1'b0;
  health_pkg::word_t hwA         = 16'h0000;
  health_pkg::word_t linkA       = 16'h0000;
  health_pkg::word_t swA         = 16'h0000;
  health_pkg::word_t senA        = 16'h0000;
  logic              fieldRd     = 1'b0;
  logic              fieldWr     = 1'b0;
  health_pkg::word_t fieldId     = 16'h0000;
  health_pkg::word_t fieldWrData = 16'h0000;
  health_pkg::word_t fieldRdData;
  logic              fieldRdValid;
  logic              fieldAccErr;
  health_pkg::word_t healthWord;
  logic              fatalFailPin;
  int                errorCnt    = 0;
  int                checkCount  = 0;
  int                cycles      = 0;
  int                i, n, bitPos;
  health_pkg::word_t sum, id;
  health_pkg::word_t maskRst[4]  = '{16'h0000, 16'h0001, 16'h0003, 16'h0001};
  row_t              rows[9]     = '{
    '{22'h000201, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0101, 16'h0003, 16'h0002},
    '{22'h008400, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0104, 16'h0003, 16'h0004},
    '{22'h3fffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0102, 16'h01ff, 16'h000e},
    '{22'h3fffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0105, 16'h001f, 16'h000e},
    '{22'h300000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0107, 16'h0003, 16'h0008},
    '{22'h000000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0104, 16'h0000, 16'h0500},
    '{22'h000000, 16'hffff, 16'hfffe, 16'hfffc, 16'hfffe, 16'h0011, 16'h0001, 16'h0000},
    '{22'h000000, 16'h0000, 16'h0000, 16'h0002, 16'h0001, 16'h0012, 16'h0003, 16'h1900},
    '{22'h100000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0107, 16'h0001, 16'h0908}};

  health_status_aggregator #(.PERSIST_INC(INC), .PERSIST_DECAY(DEC), .PERSIST_THRESH(THR)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .inputPowerOob(leaf[0]), .inputCurrentOob(leaf[1]), .inputVoltageOob(leaf[2]), .rail5vOob(leaf[3]),
    .rail3vOob(leaf[4]), .rail2vOob(leaf[5]), .ref2v5Oob(leaf[6]), .rail6vOob(leaf[7]), .groundRefOob(leaf[8]),
    .boardTempOob(leaf[9]), .portATxOverflow(leaf[10]), .portARxOverflow(leaf[11]), .portAFrameFault(leaf[12]),
    .portALineBreak(leaf[13]), .portAParityFault(leaf[14]), .portBTxOverflow(leaf[15]),
    .portBRxOverflow(leaf[16]), .portBFrameFault(leaf[17]), .portBLineBreak(leaf[18]),
    .portBParityFault(leaf[19]), .algoFault(leaf[20]), .storedDataFault(leaf[21]), .hardFail(hard),
    .hwAlertStatus(hwA), .linkAlertStatus(linkA), .swAlertStatus(swA), .sensorAlertStatus(senA),
    .fieldRd(fieldRd), .fieldWr(fieldWr), .fieldId(fieldId), .fieldWrData(fieldWrData),
    .fieldRdData(fieldRdData), .fieldRdValid(fieldRdValid), .fieldAccErr(fieldAccErr),
    .healthWord(healthWord), .fatalFailPin(fatalFailPin));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input health_pkg::word_t got, input health_pkg::word_t exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Strobe is dropped on the taking edge, so answers land one cycle later
  task automatic rdChk(input health_pkg::word_t rid, exp, input logic v, e);
    @(posedge sys_clk);
    fieldRd <= 1'b1;
    fieldId <= rid;
    @(posedge sys_clk);
    fieldRd <= 1'b0;
    #1;
    chk(fieldRdData, exp);
    chk(16'(fieldRdValid), 16'(v));
    chk(16'(fieldAccErr), 16'(e));
  endtask

  task automatic wrChk(input health_pkg::word_t wid, wdat, input logic e);
    @(posedge sys_clk);
    fieldWr     <= 1'b1;
    fieldId     <= wid;
    fieldWrData <= wdat;
    @(posedge sys_clk);
    fieldWr <= 1'b0;
    #1;
    chk(16'(fieldAccErr), 16'(e));
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      errorCnt++;
      finishTest;
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk(healthWord, 16'h0000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rdChk(16'(16'h0010 + i), maskRst[i], 1'b1, 1'b0);
    for (i = 0; i < 8; i++) rdChk(16'(16'h0100 + i), 16'h0000, 1'b1, 1'b0);
    $display("test reset done");
    for (i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      leaf  <= rows[i].leaf;
      hwA   <= rows[i].hwA;
      linkA <= rows[i].linkA;
      swA   <= rows[i].swA;
      senA  <= rows[i].senA;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(healthWord & 16'hfffe, rows[i].hexp);
      rdChk(rows[i].rid, rows[i].rexp, 1'b1, 1'b0);
    end
    $display("test table done");
    // Each leaf alone proves its bit position and which summary it feeds
    for (i = 0; i < 22; i++) begin
      @(posedge sys_clk);
      leaf <= 22'(1) << i;
      swA  <= 16'h0000;
      repeat (2) @(posedge sys_clk);
      #1;
      sum    = i < 10 ? 16'h0002 : i < 20 ? 16'h0004 : 16'h0008;
      id     = i < 9 ? 16'h0102 : i == 9 ? 16'h0103 : i < 15 ? 16'h0105 : i < 20 ? 16'h0106 : 16'h0107;
      bitPos = i < 9 ? i : i == 9 ? 0 : i < 15 ? i - 10 : i < 20 ? i - 15 : i - 20;
      chk(healthWord & 16'h00fe, sum);
      rdChk(id, 16'(1) << bitPos, 1'b1, 1'b0);
    end
    $display("test leaf sweep done");
    @(posedge sys_clk);
    leaf <= 22'h000000;
    hwA  <= 16'h0008;
    senA <= 16'h0001;
    wrChk(16'h0010, 16'h0008, 1'b0);
    wrChk(16'h0013, 16'h0000, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(healthWord & 16'hfffe, 16'h0300);
    rdChk(16'h0010, 16'h0008, 1'b1, 1'b0);
    wrChk(16'h0200, 16'h1234, 1'b1);
    rdChk(16'h0200, 16'h0000, 1'b0, 1'b1);
    $display("test field write done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(healthWord, 16'h0000);
    chk(16'(fatalFailPin), 16'h0000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(healthWord, 16'h1100);
    $display("test mid-run reset done");
    @(posedge sys_clk);
    leaf <= 22'h000008;
    for (i = 1; i <= THR / INC; i++) begin
      @(posedge sys_clk);
      #1;
      chk(healthWord & 16'h000f, 16'h0002);
    end
    @(posedge sys_clk);
    #1;
    chk(healthWord & 16'h000f, 16'h0003);
    chk(16'(fatalFailPin), 16'h0001);
    @(posedge sys_clk);
    leaf <= 22'h000000;
    @(posedge sys_clk);
    #1;
    chk(healthWord & 16'h000f, 16'h0001);
    n = 0;
    while (healthWord[0] !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
      chk(16'(fatalFailPin), 16'(healthWord[0]));
    end
    chk(healthWord & 16'h000f, 16'h0000);
    // Count peaks two steps above threshold, then decays one step per cycle
    chk(16'(n), 16'(2 * INC / DEC + 1));
    $display("test persistence done");
    @(posedge sys_clk);
    hard <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(16'(fatalFailPin), 16'h0001);
    rdChk(16'h0100, 16'h1101, 1'b1, 1'b0);
    @(posedge sys_clk);
    hard <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(healthWord, 16'h1100);
    $display("test hard fail done");
    @(posedge sys_clk);
    fieldRd <= 1'b1;
    fieldId <= 16'h0011;
    @(posedge sys_clk);
    fieldId <= 16'h0012;
    #1;
    chk(fieldRdData, 16'h0001);
    @(posedge sys_clk);
    fieldRd <= 1'b0;
    #1;
    chk(fieldRdData, 16'h0003);
    chk(16'(fieldRdValid), 16'h0001);
    @(posedge sys_clk);
    #1;
    chk(16'(fieldRdValid), 16'h0000);
    $display("test back-to-back reads done");
    // Read and write together: read sees the old mask, the write still lands
    @(posedge sys_clk);
    fieldRd     <= 1'b1;
    fieldWr     <= 1'b1;
    fieldId     <= 16'h0013;
    fieldWrData <= 16'h0000;
    @(posedge sys_clk);
    fieldRd <= 1'b0;
    fieldWr <= 1'b0;
    #1;
    chk(fieldRdData, 16'h0001);
    chk(16'(fieldAccErr), 16'h0000);
    rdChk(16'h0013, 16'h0000, 1'b1, 1'b0);
    chk(healthWord, 16'h0000);
    $display("test read with write done");
    finishTest;
  end
endmodule
